/* File: logic/event_detector.sv */
// Over/under current and voltage event detector with control registers
//
// The plain strobed port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none
`include "event_detect_defines.svh"

// Functional notes
// [R1] Current window 31:30 selects 1,2,4,8 halves
// [R2] Count out-of-limit samples; threshold marks effective
// [R3] Event after window consecutive effective halves
// [R4] Current threshold 29:24, n means n+1
// [R5] Voltage window 23:22, same consecutive rule
// [R6] Voltage threshold 21:16, n means n+1
// [R7] Software keeps reserved 15:10 at zero
// [R8] Bit 8 selects filtered channel B over-current
// [R9] Bits 7,6 select filtered channel A tests
// [R10] Bits 5,4 select filtered voltage tests
// [R11] Bit 9 selects filtered channel B under-current
// [R12] Zero crossings delimit halves, reset count
module event_detector (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [`DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire event_detect_pkg::wave_s wave_in,
  input wire event_detect_pkg::limits_s limits_in,
  output logic [`DATA_W-1:0] rd_data_out,
  output logic irq_out
);

  // ****************************************
  // Functions
  // ****************************************
  function automatic event_detect_pkg::sample_t pick(
    input logic use_hpf,
    input event_detect_pkg::sample_t raw,
    input event_detect_pkg::sample_t hpf
  );
    pick = use_hpf ? hpf : raw;
  endfunction

  function automatic logic [`DATA_W-1:0] ctrl_word(input event_detect_pkg::ctrl_s c);
    logic [`DATA_W-1:0] w;
    w = '0;
    w[`CUR_WIN_HI:`CUR_WIN_LO] = c.cur_win;
    w[`CUR_THR_HI:`CUR_THR_LO] = c.cur_thr;
    w[`VOLT_WIN_HI:`VOLT_WIN_LO] = c.volt_win;
    w[`VOLT_THR_HI:`VOLT_THR_LO] = c.volt_thr;
    w[`SEL_CHB_UNDER] = c.sel[`T_CHB_UNDER];
    w[`SEL_CHB_OVER] = c.sel[`T_CHB_OVER];
    w[`SEL_CHA_UNDER] = c.sel[`T_CHA_UNDER];
    w[`SEL_CHA_OVER] = c.sel[`T_CHA_OVER];
    w[`SEL_U_UNDER] = c.sel[`T_U_UNDER];
    w[`SEL_U_OVER] = c.sel[`T_U_OVER];
    ctrl_word = w;
  endfunction

  function automatic event_detect_pkg::ctrl_s ctrl_fields(input logic [`DATA_W-1:0] w);
    event_detect_pkg::ctrl_s c;
    c = '0;
    c.cur_win = w[`CUR_WIN_HI:`CUR_WIN_LO];
    c.cur_thr = w[`CUR_THR_HI:`CUR_THR_LO];
    c.volt_win = w[`VOLT_WIN_HI:`VOLT_WIN_LO];
    c.volt_thr = w[`VOLT_THR_HI:`VOLT_THR_LO];
    c.sel[`T_CHB_UNDER] = w[`SEL_CHB_UNDER];
    c.sel[`T_CHB_OVER] = w[`SEL_CHB_OVER];
    c.sel[`T_CHA_UNDER] = w[`SEL_CHA_UNDER];
    c.sel[`T_CHA_OVER] = w[`SEL_CHA_OVER];
    c.sel[`T_U_UNDER] = w[`SEL_U_UNDER];
    c.sel[`T_U_OVER] = w[`SEL_U_OVER];
    ctrl_fields = c;
  endfunction

  // ****************************************
  // State
  // ****************************************
  event_detect_pkg::top_state_s state;
  event_detect_pkg::top_state_s next_state;

  event_detect_pkg::sample_t test_sample [`N_TESTS];
  event_detect_pkg::mag_t test_limit [`N_TESTS];
  logic [`N_TESTS-1:0] test_under;
  logic [`N_TESTS-1:0] test_is_volt;
  logic [`N_TESTS-1:0] test_event;
  logic [`RUN_W-1:0] cur_halves;
  logic [`RUN_W-1:0] volt_halves;
  logic ctrl_write;

  // ****************************************
  // Source selection
  // ****************************************
  assign test_sample[`T_CHA_OVER] =
    pick(state.ctrl.sel[`T_CHA_OVER], wave_in.cha_raw, wave_in.cha_hpf); // see [R9]
  assign test_sample[`T_CHA_UNDER] =
    pick(state.ctrl.sel[`T_CHA_UNDER], wave_in.cha_raw, wave_in.cha_hpf); // see [R9]
  assign test_sample[`T_CHB_OVER] =
    pick(state.ctrl.sel[`T_CHB_OVER], wave_in.chb_raw, wave_in.chb_hpf); // see [R8]
  assign test_sample[`T_CHB_UNDER] =
    pick(state.ctrl.sel[`T_CHB_UNDER], wave_in.chb_raw, wave_in.chb_hpf); // see [R11]
  assign test_sample[`T_U_OVER] =
    pick(state.ctrl.sel[`T_U_OVER], wave_in.u_raw, wave_in.u_hpf); // see [R10]
  assign test_sample[`T_U_UNDER] =
    pick(state.ctrl.sel[`T_U_UNDER], wave_in.u_raw, wave_in.u_hpf); // see [R10]

  assign test_limit[`T_CHA_OVER] = limits_in.cha_over;
  assign test_limit[`T_CHA_UNDER] = limits_in.cha_under;
  assign test_limit[`T_CHB_OVER] = limits_in.chb_over;
  assign test_limit[`T_CHB_UNDER] = limits_in.chb_under;
  assign test_limit[`T_U_OVER] = limits_in.u_over;
  assign test_limit[`T_U_UNDER] = limits_in.u_under;

  always_comb
  begin
    test_under = '0;
    test_is_volt = '0;
    test_under[`T_CHA_UNDER] = 1'b1;
    test_under[`T_CHB_UNDER] = 1'b1;
    test_under[`T_U_UNDER] = 1'b1;
    test_is_volt[`T_U_OVER] = 1'b1;
    test_is_volt[`T_U_UNDER] = 1'b1;
  end

  assign cur_halves = event_detect_pkg::window_halves(state.ctrl.cur_win); // see [R1]
  assign volt_halves = event_detect_pkg::window_halves(state.ctrl.volt_win); // see [R5]

  // Changing the setup mid-run would mix old and new criteria, so restart
  assign ctrl_write = wr_en_in && (addr_in == `CTRL_ADDR);

  // ****************************************
  // Limit tests
  // ****************************************
  genvar i;
  generate
    for (i = 0; i < `N_TESTS; i++)
    begin : g_test
      half_cycle_test u_test (
        .clk_in(clk_in),
        .rstn_in(rstn_in),
        .valid_in(wave_in.valid),
        .clear_in(ctrl_write),
        .sample_in(test_sample[i]),
        .limit_in(test_limit[i]),
        .under_in(test_under[i]),
        .threshold_in(test_is_volt[i] ? state.ctrl.volt_thr : state.ctrl.cur_thr), // see [R4] [R6]
        .window_in(test_is_volt[i] ? volt_halves : cur_halves), // see [R1] [R5]
        .event_out(test_event[i])
      );
    end
  endgenerate

  // ****************************************
  // Registers
  // ****************************************
  always_comb
  begin
    logic [`N_TESTS-1:0] clr;
    clr = '0;
    next_state = state;
    next_state.rd_data = '0;
    if (wr_en_in)
    begin
      if (addr_in == `CTRL_ADDR)
      begin
        // Reserved bits are not stored and read as zero
        next_state.ctrl = ctrl_fields(wr_data_in); // see [R7]
      end
      else if (addr_in == `STATUS_ADDR)
      begin
        clr = wr_data_in[`N_TESTS-1:0];
      end
      else if (addr_in == `MASK_ADDR)
      begin
        next_state.mask = wr_data_in[`N_TESTS-1:0];
      end
    end
    if (rd_en_in)
    begin
      if (addr_in == `CTRL_ADDR)
      begin
        next_state.rd_data = ctrl_word(state.ctrl);
      end
      else if (addr_in == `STATUS_ADDR)
      begin
        next_state.rd_data = `DATA_W'(state.status);
      end
      else if (addr_in == `MASK_ADDR)
      begin
        next_state.rd_data = `DATA_W'(state.mask);
      end
      else
      begin
        next_state.rd_data = '0;
      end
    end
    // New event wins over a clear in the same cycle
    next_state.status = (state.status & ~clr) | test_event; // see [R3]
    next_state.irq = |(next_state.status & next_state.mask);
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state.ctrl <= ctrl_fields(`CTRL_RESET);
      state.status <= `STATUS_RESET;
      state.mask <= `MASK_RESET;
      state.rd_data <= '0;
      state.irq <= 1'b0;
    end
    else
    begin
      state <= next_state;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  assign rd_data_out = state.rd_data;
  assign irq_out = state.irq;

endmodule

`default_nettype wire

/* File: include/event_detect_defines.svh */
// Constants of the over/under current and voltage event detector
`ifndef EVENT_DETECT_DEFINES_SVH
`define EVENT_DETECT_DEFINES_SVH

// ****************************************
// Widths
// ****************************************
`define ADDR_W 8
`define DATA_W 32
`define SAMPLE_W 24
`define N_TESTS 6
`define CNT_W 7
`define RUN_W 4
`define THR_W 6
`define WIN_W 2

// ****************************************
// Register offsets
// ****************************************
`define CTRL_ADDR 8'h06
`define STATUS_ADDR 8'h07
`define MASK_ADDR 8'h08

// ****************************************
// Control field positions
// ****************************************
`define CUR_WIN_HI 31
`define CUR_WIN_LO 30
`define CUR_THR_HI 29
`define CUR_THR_LO 24
`define VOLT_WIN_HI 23
`define VOLT_WIN_LO 22
`define VOLT_THR_HI 21
`define VOLT_THR_LO 16
`define SEL_CHB_UNDER 9
`define SEL_CHB_OVER 8
`define SEL_CHA_UNDER 7
`define SEL_CHA_OVER 6
`define SEL_U_UNDER 5
`define SEL_U_OVER 4

// ****************************************
// Test indices in status and mask
// ****************************************
`define T_CHA_OVER 0
`define T_CHA_UNDER 1
`define T_CHB_OVER 2
`define T_CHB_UNDER 3
`define T_U_OVER 4
`define T_U_UNDER 5

// ****************************************
// Reset values and counts
// ****************************************
`define CTRL_RESET 32'h0000_0000
`define STATUS_RESET 6'h00
`define MASK_RESET 6'h00
`define ONE_SAMPLE 7'h01
`define SAT_COUNT 7'h40
`define ONE_RUN 4'h1
`define ZERO_RUN 4'h0
`define WIN_ONE 4'h1

`endif

/* File: include/event_detect_pkg.sv */
// Types shared by the event detector modules
`default_nettype none
`include "event_detect_defines.svh"

package event_detect_pkg;

  typedef logic signed [`SAMPLE_W-1:0] sample_t;
  typedef logic [`SAMPLE_W-1:0] mag_t;

  typedef struct packed {
    logic valid;
    sample_t cha_raw;
    sample_t cha_hpf;
    sample_t chb_raw;
    sample_t chb_hpf;
    sample_t u_raw;
    sample_t u_hpf;
  } wave_s;

  typedef struct packed {
    mag_t cha_over;
    mag_t cha_under;
    mag_t chb_over;
    mag_t chb_under;
    mag_t u_over;
    mag_t u_under;
  } limits_s;

  typedef struct packed {
    logic [`WIN_W-1:0] cur_win;
    logic [`THR_W-1:0] cur_thr;
    logic [`WIN_W-1:0] volt_win;
    logic [`THR_W-1:0] volt_thr;
    logic [`N_TESTS-1:0] sel;
  } ctrl_s;

  typedef struct packed {
    logic primed;
    logic prev_sign;
    logic [`CNT_W-1:0] count;
    logic [`RUN_W-1:0] run;
    logic event_flag;
  } test_state_s;

  typedef struct packed {
    ctrl_s ctrl;
    logic [`N_TESTS-1:0] status;
    logic [`N_TESTS-1:0] mask;
    logic [`DATA_W-1:0] rd_data;
    logic irq;
  } top_state_s;

  // Window code to number of half-cycles: 1, 2, 4, 8
  function automatic logic [`RUN_W-1:0] window_halves(input logic [`WIN_W-1:0] code);
    window_halves = `WIN_ONE << code;
  endfunction

endpackage

`default_nettype wire

/* File: logic/half_cycle_test.sv */
// One limit test: per half-cycle sample count and consecutive run
`timescale 1ns/100ps
`default_nettype none
`include "event_detect_defines.svh"

module half_cycle_test (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic valid_in,
  input wire logic clear_in,
  input wire event_detect_pkg::sample_t sample_in,
  input wire event_detect_pkg::mag_t limit_in,
  input wire logic under_in,
  input wire logic [`THR_W-1:0] threshold_in,
  input wire logic [`RUN_W-1:0] window_in,
  output logic event_out
);

  event_detect_pkg::test_state_s state;
  event_detect_pkg::test_state_s next_state;
  event_detect_pkg::mag_t mag;
  logic beyond;
  logic sign;
  logic effective;
  logic [`RUN_W-1:0] run_inc;

  assign sign = sample_in[`SAMPLE_W-1];
  assign mag = sign ? event_detect_pkg::mag_t'(-sample_in) : event_detect_pkg::mag_t'(sample_in);
  assign beyond = under_in ? (mag < limit_in) : (mag > limit_in);
  // Threshold n means n+1 samples
  assign effective = state.count >= (`CNT_W'(threshold_in) + `ONE_SAMPLE); // see [R2] [R4] [R6]
  assign run_inc = state.run + `ONE_RUN;

  always_comb
  begin
    next_state = state;
    next_state.event_flag = 1'b0;
    if (clear_in)
    begin
      next_state = '0;
    end
    else if (valid_in)
    begin
      if (!state.primed)
      begin
        next_state.primed = 1'b1;
        next_state.prev_sign = sign;
        next_state.count = beyond ? `ONE_SAMPLE : '0;
      end
      else if (sign != state.prev_sign)
      begin
        // Zero crossing closes the half-cycle
        next_state.prev_sign = sign; // see [R12]
        next_state.count = beyond ? `ONE_SAMPLE : '0; // see [R12]
        if (effective)
        begin
          if (run_inc >= window_in) // see [R3]
          begin
            next_state.event_flag = 1'b1;
            next_state.run = `ZERO_RUN;
          end
          else
          begin
            next_state.run = run_inc;
          end
        end
        else
        begin
          next_state.run = `ZERO_RUN; // see [R3]
        end
      end
      else if (beyond && state.count != `SAT_COUNT)
      begin
        // Saturate: 64 is the largest threshold
        next_state.count = state.count + `ONE_SAMPLE; // see [R2]
      end
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      state <= '0;
    end
    else
    begin
      state <= next_state;
    end
  end

  assign event_out = state.event_flag;

endmodule

`default_nettype wire

/* File: verif/event_detector_chk.sv */
// Assertions on the event detector ports
`timescale 1ns/100ps
`default_nettype none
`include "event_detect_defines.svh"

// ********
// Checker
// ********
module event_detector_chk (
  input wire logic clk_in,
  input wire logic rstn_in,
  input wire logic [`ADDR_W-1:0] addr_in,
  input wire logic [`DATA_W-1:0] wr_data_in,
  input wire logic wr_en_in,
  input wire logic rd_en_in,
  input wire event_detect_pkg::wave_s wave_in,
  input wire logic [`DATA_W-1:0] rd_data_out,
  input wire logic irq_out
);
  logic [`DATA_W-1:0] ctrl_sh;
  logic [`N_TESTS-1:0] mask_sh;
  default clocking @(posedge clk_in); endclocking
  default disable iff (!rstn_in);

  // Shadows only hold what the port stores
  always_ff @(posedge clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      ctrl_sh <= 32'h0;
      mask_sh <= 6'h0;
    end
    else
    begin
      if (wr_en_in && addr_in == `CTRL_ADDR)
        ctrl_sh <= wr_data_in & 32'hFFFF_03F0;
      if (wr_en_in && addr_in == `MASK_ADDR)
        mask_sh <= wr_data_in[5:0];
    end
  end

  sequence s_rd(a);
    rd_en_in && addr_in == a;
  endsequence
  property p_ctrl_rb;
    s_rd(`CTRL_ADDR) |=> rd_data_out == ctrl_sh;
  endproperty
  property p_mask_rb;
    s_rd(`MASK_ADDR) |=> rd_data_out == {26'h0, mask_sh};
  endproperty
  property p_stat_hi;
    s_rd(`STATUS_ADDR) |=> rd_data_out[31:6] == 26'h0;
  endproperty
  property p_unmapped;
    rd_en_in && !(addr_in inside {`CTRL_ADDR, `STATUS_ADDR, `MASK_ADDR}) |=> rd_data_out == 32'h0;
  endproperty
  property p_rd_idle;
    !rd_en_in |=> rd_data_out == 32'h0;
  endproperty
  // Events land only two edges after a sample
  property p_irq_rise;
    $rose(irq_out) |-> $past(wave_in.valid, 2) || $past(wr_en_in);
  endproperty
  property p_irq_fall;
    $fell(irq_out) |-> $past(wr_en_in);
  endproperty
  property p_irq_masked;
    mask_sh == 6'h0 |-> !irq_out;
  endproperty
  a_ctrl_rb: assert property (p_ctrl_rb) else $error("control readback wrong");
  a_mask_rb: assert property (p_mask_rb) else $error("mask readback wrong");
  a_stat_hi: assert property (p_stat_hi) else $error("status upper bits set");
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  a_rd_idle: assert property (p_rd_idle) else $error("read data without strobe");
  a_irq_rise: assert property (p_irq_rise) else $error("event off a boundary");
  a_irq_fall: assert property (p_irq_fall) else $error("irq fell without write");
  a_irq_masked: assert property (p_irq_masked) else $error("irq while masked");
endmodule

bind event_detector event_detector_chk chk (
  .clk_in,
  .rstn_in,
  .addr_in,
  .wr_data_in,
  .wr_en_in,
  .rd_en_in,
  .wave_in,
  .rd_data_out,
  .irq_out
);
`default_nettype wire

/* File: verif/tb.sv */
// Self-checking bench of the event detector
`timescale 1ns/100ps
`default_nettype none
`include "event_detect_defines.svh"

// ********
// Bench
// ********
module tb;
  logic clk_in = 1'h0;
  logic rstn_in = 1'h0;
  logic [7:0] addr_in = 8'h0;
  logic [31:0] wr_data_in = 32'h0;
  logic wr_en_in = 1'h0;
  logic rd_en_in = 1'h0;
  event_detect_pkg::wave_s wave_in = '0;
  event_detect_pkg::limits_s limits_in;
  logic [31:0] rd_data_out;
  logic irq_out;
  logic [31:0] d;
  int err_total = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [23:0] P = 24'h000014;
  localparam logic [23:0] N = 24'hFFFFEC;

  // Over limits 10, under limits 5
  assign limits_in = {3{24'h00000A, 24'h000005}};
  always #2.5 clk_in = ~clk_in;

  event_detector dut (
    .clk_in,
    .rstn_in,
    .addr_in,
    .wr_data_in,
    .wr_en_in,
    .rd_en_in,
    .wave_in,
    .limits_in,
    .rd_data_out,
    .irq_out
  );

  always @(posedge clk_in)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      err_total++;
      complete_run();
    end
  end

  task automatic chk_reg(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_irq(input logic exp);
    #1;
    chk_reg({31'h0, irq_out}, {31'h0, exp});
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wr_data_in <= v;
    wr_en_in <= 1'h1;
    @(posedge clk_in);
    wr_en_in <= 1'h0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_en_in <= 1'h1;
    @(posedge clk_in);
    rd_en_in <= 1'h0;
    #1 d = rd_data_out;
  endtask
  task automatic smp(input logic [23:0] r, input logic [23:0] h);
    @(posedge clk_in);
    wave_in <= {1'h1, r, h, r, h, r, h};
    @(posedge clk_in);
    wave_in.valid <= 1'h0;
  endtask
  // Status read then full clear
  task automatic st(input logic [31:0] e);
    rd(`STATUS_ADDR);
    chk_reg(d, e);
    wr(`STATUS_ADDR, 32'h3F);
  endtask

  task automatic t_reset;
    for (int a = 6; a < 10; a++)
    begin
      rd(a[7:0]);
      chk_reg(d, 32'h0);
    end
    wr(8'h09, 32'hFFFF_FFFF);
    // Reserved 15:10 stay zero from software
    wr(`CTRL_ADDR, 32'hFFFF_03FF);
    rd(8'h09);
    chk_reg(d, 32'h0);
    rd(`CTRL_ADDR);
    chk_reg(d, 32'hFFFF_03F0);
    wr(`CTRL_ADDR, 32'h0);
    $display("reset and fields done");
  endtask

  task automatic t_basic;
    wr(`MASK_ADDR, 32'h3F);
    smp(P, P);
    smp(N, N);
    rd(`STATUS_ADDR);
    chk_reg(d, 32'h15);
    chk_irq(1'h1);
    wr(`MASK_ADDR, 32'h0);
    chk_irq(1'h0);
    wr(`MASK_ADDR, 32'h3F);
    chk_irq(1'h1);
    wr(`STATUS_ADDR, 32'h01);
    st(32'h14);
    chk_irq(1'h0);
    $display("event and interrupt done");
  endtask

  // Largest threshold: 63 samples fail, 64 pass
  task automatic t_thr;
    for (int k = 0; k < 2; k++)
    begin
      wr(`CTRL_ADDR, k ? 32'h003F_0000 : 32'h3F00_0000);
      repeat (63) smp(P, P);
      smp(N, N);
      st(k ? 32'h05 : 32'h10);
      repeat (63) smp(N, N);
      smp(P, P);
      st(32'h15);
    end
    $display("threshold done");
  endtask

  task automatic t_win;
    int nc;
    int nv;
    for (int c = 0; c < 4; c++)
    begin
      nc = 1 << c;
      nv = 8 >> c;
      wr(`CTRL_ADDR, (c << 30) | ((3 - c) << 22));
      smp(P, P);
      for (int k = 1; k < 9; k++)
      begin
        smp(k % 2 ? N : P, k % 2 ? N : P);
        st((k % nc ? 32'h0 : 32'h05) | (k % nv ? 32'h0 : 32'h10));
      end
    end
    $display("window done");
  endtask

  // A short half must restart the run
  task automatic t_restart;
    logic [7:0] pat;
    pat = 8'h9B;
    wr(`CTRL_ADDR, 32'h41C0_0000);
    for (int i = 0; i < 8; i++)
    begin
      smp(pat[i] ? P : N, pat[i] ? P : N);
      if (i == 5)
        st(32'h0);
      if (i == 7)
        st(32'h05);
    end
    $display("restart done");
  endtask

  task automatic t_src;
    logic [31:0] c;
    for (int i = 0; i < 7; i++)
    begin
      c = (i < 6) ? (32'h10 << i) : 32'h0;
      wr(`CTRL_ADDR, c);
      smp(24'h000002, P);
      smp(24'hFFFFFE, N);
      st({26'h0, ~c[5], c[4], ~c[9], c[8], ~c[7], c[6]});
    end
    $display("source select done");
  endtask

  task automatic complete_run;
    $display("checks %0d mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  initial
  begin
    repeat (2) @(posedge clk_in);
    rstn_in <= 1'h1;
    chk_irq(1'h0);
    t_reset();
    t_basic();
    t_thr();
    t_win();
    t_restart();
    t_src();
    complete_run();
  end
endmodule
`default_nettype wire
